// File: design/hsp_handler_status_port.sv
// second output port, first port top bit and shared status lines
module hsp_handler_status_port #(
    parameter int PORT_W = hsp_pkg::HSP_PORT_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // port data from the instrument, 1 = asserted
    input wire logic [PORT_W-1:0] port_b_i,
    input wire logic first_output_bit7_i,
    // configuration
    input wire logic done_sel_i,
    input wire logic ready_sel_i,
    input wire logic point_trig_en_i,
    // sequencer events, one-cycle pulses
    input wire logic arm_i,
    input wire logic point_ready_i,
    input wire logic points_done_i,
    input wire logic all_done_i,
    // trigger line from outside, active low
    input wire logic trig_n_i,
    // handler lines, active low
    output logic [PORT_W-1:0] second_output_n_o,
    output logic first_output_bit7_n_o,
    // status back to the instrument
    output logic meas_done_o,
    output logic trig_ready_o,
    output logic trig_taken_o
);
    hsp_pkg::hsp_state_t state_q;
    hsp_pkg::hsp_state_t state_d;
    logic meas_done_q;
    logic meas_done_d;
    logic trig_ready_q;
    logic trig_ready_d;
    logic trig_taken_q;
    logic trig_taken_d;
    logic [2:0] trig_sync_q;
    logic [2:0] trig_sync_d;
    logic trig_lvl_q;
    logic trig_lvl_d;
    logic trig_ev;
    logic [PORT_W-1:0] port_val;
    logic [PORT_W:0] line_val;
    logic [PORT_W:0] line_n;

    // trigger line synchroniser; only stages two and three are compared
    always_comb
    begin
        trig_sync_d = {trig_sync_q[1:0], trig_n_i};
        trig_lvl_d = trig_lvl_q;
        trig_ev = 1'b0;
        if (trig_sync_q[1] == trig_sync_q[2] && trig_sync_q[2] != trig_lvl_q)
        begin
            trig_lvl_d = trig_sync_q[2];
            trig_ev = (trig_sync_q[2] == hsp_pkg::HSP_LINE_ACTIVE);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            trig_sync_q <= {3{hsp_pkg::HSP_LINE_IDLE}};
            trig_lvl_q <= hsp_pkg::HSP_LINE_IDLE;
        end
        else
        begin
            trig_sync_q <= trig_sync_d;
            trig_lvl_q <= trig_lvl_d;
        end
    end

    // trigger sequencing; triggers outside armed states are dropped
    always_comb
    begin
        state_d = state_q;
        meas_done_d = meas_done_q;
        trig_taken_d = 1'b0;
        case (state_q)
            hsp_pkg::HSP_IDLE:
            begin
                if (arm_i)
                begin
                    state_d = hsp_pkg::HSP_ARMED;
                end
            end
            hsp_pkg::HSP_ARMED:
            begin
                if (trig_ev)
                begin
                    state_d = hsp_pkg::HSP_MEAS;
                    trig_taken_d = 1'b1;
                    meas_done_d = 1'b0;
                end
            end
            hsp_pkg::HSP_MEAS:
            begin
                if (points_done_i)
                begin
                    state_d = hsp_pkg::HSP_IDLE;
                end
                else if (point_ready_i && point_trig_en_i)
                begin
                    state_d = hsp_pkg::HSP_WAIT_PT;
                end
            end
            hsp_pkg::HSP_WAIT_PT:
            begin
                if (trig_ev)
                begin
                    state_d = hsp_pkg::HSP_MEAS;
                    trig_taken_d = 1'b1;
                end
            end
            default:
            begin
                state_d = hsp_pkg::HSP_IDLE;
            end
        endcase
        // completion set wins over the clear at trigger time
        if (all_done_i)
        begin
            meas_done_d = 1'b1;
        end
        trig_ready_d = (state_d == hsp_pkg::HSP_ARMED) ||
                       (state_d == hsp_pkg::HSP_WAIT_PT);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= hsp_pkg::HSP_IDLE;
            meas_done_q <= hsp_pkg::HSP_DONE_RST;
            trig_ready_q <= hsp_pkg::HSP_READY_RST;
            trig_taken_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            meas_done_q <= meas_done_d;
            trig_ready_q <= trig_ready_d;
            trig_taken_q <= trig_taken_d;
        end
    end

    // pin sharing: a status function fully hides the port bit
    always_comb
    begin
        port_val = port_b_i;
        if (done_sel_i)
        begin
            port_val[hsp_pkg::HSP_BIT_DONE] = meas_done_q;
        end
        if (ready_sel_i)
        begin
            port_val[hsp_pkg::HSP_BIT_READY] = trig_ready_q;
        end
        line_val = {first_output_bit7_i, port_val};
    end

    // one registered inverting stage for all nine lines
    hsp_pin_drv #(
        .W(PORT_W + 1)
    ) u_lines (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .val_i(line_val),
        .line_n_o(line_n)
    );

    assign second_output_n_o = line_n[PORT_W-1:0];
    assign first_output_bit7_n_o = line_n[PORT_W];
    assign meas_done_o = meas_done_q;
    assign trig_ready_o = trig_ready_q;
    assign trig_taken_o = trig_taken_q;

    // checks on status, pins and sequencing
    a_done_pin_low: assert property (@(posedge clk_i) disable iff (rst_i)
        done_sel_i && meas_done_q |=>
        second_output_n_o[hsp_pkg::HSP_BIT_DONE] == hsp_pkg::HSP_LINE_ACTIVE)
        else $error("done pin not low while done");
    a_ready_pin_low: assert property (@(posedge clk_i) disable iff (rst_i)
        ready_sel_i && trig_ready_q |=>
        second_output_n_o[hsp_pkg::HSP_BIT_READY] == hsp_pkg::HSP_LINE_ACTIVE)
        else $error("ready pin not low while ready");
    a_ready_tracks_state: assert property (@(posedge clk_i) disable iff (rst_i)
        trig_ready_q == (state_q == hsp_pkg::HSP_ARMED ||
                         state_q == hsp_pkg::HSP_WAIT_PT))
        else $error("ready flag disagrees with state");
    a_port_bits_inv: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> second_output_n_o[hsp_pkg::HSP_BIT_DONE-1:0] ==
                 ~$past(port_b_i[hsp_pkg::HSP_BIT_DONE-1:0]) &&
                 first_output_bit7_n_o == ~$past(first_output_bit7_i))
        else $error("port lines not inverted data");
    a_bit6_plain: assert property (@(posedge clk_i) disable iff (rst_i)
        !done_sel_i |=> second_output_n_o[hsp_pkg::HSP_BIT_DONE] ==
                        ~$past(port_b_i[hsp_pkg::HSP_BIT_DONE]))
        else $error("bit 6 not passed through");
    a_status_hides_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        ready_sel_i |=> second_output_n_o[hsp_pkg::HSP_BIT_READY] ==
                        ~$past(trig_ready_q))
        else $error("bit 7 leaks through status pin");
    a_first_trig_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == hsp_pkg::HSP_ARMED && trig_ev |=>
        !trig_ready_q && trig_taken_o ##1 !trig_taken_o)
        else $error("ready not dropped on first trigger");
    a_done_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == hsp_pkg::HSP_ARMED && trig_ev && !all_done_i |=>
        !meas_done_q)
        else $error("done not cleared at measurement start");
    a_done_set: assert property (@(posedge clk_i) disable iff (rst_i)
        all_done_i |=> meas_done_q)
        else $error("done not set on completion");
    a_next_point: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == hsp_pkg::HSP_MEAS && point_ready_i && point_trig_en_i &&
        !points_done_i |=> trig_ready_q)
        else $error("ready not back after point");
    a_rearm: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == hsp_pkg::HSP_IDLE && arm_i |=> trig_ready_q)
        else $error("ready not back on rearm");
endmodule

// File: design/hsp_pkg.sv
// shared constants and types for the handler status port
package hsp_pkg;
    // width of the second parallel output port
    localparam int HSP_PORT_W = 8;
    // bit positions of the two shared pins inside the second port
    localparam int HSP_BIT_DONE = 6;
    localparam int HSP_BIT_READY = 7;
    // connector pins that carry the shared functions
    localparam int HSP_PIN_DONE = 19;
    localparam int HSP_PIN_READY = 20;
    // negative logic line levels
    localparam logic HSP_LINE_ACTIVE = 1'b0;
    localparam logic HSP_LINE_IDLE = 1'b1;
    // reset values of the logical flags (1 = asserted)
    localparam logic HSP_DONE_RST = 1'b0;
    localparam logic HSP_READY_RST = 1'b0;

    // trigger sequencing states
    typedef enum logic [1:0] {
        HSP_IDLE = 2'b00,
        HSP_ARMED = 2'b01,
        HSP_MEAS = 2'b10,
        HSP_WAIT_PT = 2'b11
    } hsp_state_t;
endpackage

// File: design/hsp_pin_drv.sv
// registered negative logic output stage for a group of handler lines
module hsp_pin_drv #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // logical values, 1 = asserted
    input wire logic [W-1:0] val_i,
    // line levels, low = asserted
    output logic [W-1:0] line_n_o
);
    logic [W-1:0] line_d;

    // inversion to line level; no polarity switch here by design
    always_comb
    begin
        line_d = ~val_i;
    end

    // lines idle high from reset so the handler sees nothing asserted
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            line_n_o <= {W{hsp_pkg::HSP_LINE_IDLE}};
        end
        else
        begin
            line_n_o <= line_d;
        end
    end
endmodule

// File: sim/hsp_handler_model.sv
// bench model of the part handler that drives the trigger line
module hsp_handler_model (
    // clock
    input wire logic clk_i,
    // request from the bench to start the next part
    input wire logic fire_i,
    // trigger line, active low, pulled up when idle
    output logic trig_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // fires whenever the bench asks, idle or not; held low four cycles for the syncs
    always @(posedge clk_i)
    begin
        if (fire_i)
            cnt <= 4;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign trig_n_o = (cnt > 0) ? 1'b0 : 1'b1;
endmodule

// File: sim/tb.sv
// self-checking bench for the handler status port
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] port_b_i = 8'h00;
    logic first_output_bit7_i = 1'b0;
    logic done_sel_i = 1'b0;
    logic ready_sel_i = 1'b0;
    logic point_trig_en_i = 1'b0;
    logic arm_i = 1'b0;
    logic point_ready_i = 1'b0;
    logic points_done_i = 1'b0;
    logic all_done_i = 1'b0;
    logic fire = 1'b0;
    logic trig_n;
    logic [7:0] lines;
    logic bit7_n;
    logic done;
    logic ready;
    logic taken;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    hsp_handler_status_port hsp_handler_status_port_inst (
        .clk_i(clk_i), .rst_i(rst_i), .port_b_i(port_b_i),
        .first_output_bit7_i(first_output_bit7_i),
        .done_sel_i(done_sel_i), .ready_sel_i(ready_sel_i),
        .point_trig_en_i(point_trig_en_i), .arm_i(arm_i),
        .point_ready_i(point_ready_i), .points_done_i(points_done_i),
        .all_done_i(all_done_i), .trig_n_i(trig_n),
        .second_output_n_o(lines), .first_output_bit7_n_o(bit7_n),
        .meas_done_o(done), .trig_ready_o(ready), .trig_taken_o(taken)
    );
    hsp_handler_model hsp_handler_model_inst (
        .clk_i(clk_i), .fire_i(fire), .trig_n_o(trig_n)
    );

    // inputs move 1 ns after the rising edge, away from sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string name, input logic [7:0] got,
                       input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one-cycle event: arm, point ready, points done, all done
    task automatic ev(input logic [3:0] m);
        {arm_i, point_ready_i, points_done_i, all_done_i} = m;
        step(1);
        {arm_i, point_ready_i, points_done_i, all_done_i} = 4'h0;
    endtask
    // handler trigger, acceptance awaited under a bound
    task automatic trig();
        int i;
        fire = 1'b1;
        step(1);
        fire = 1'b0;
        for (i = 0; i < 20 && taken !== 1'b1; i++)
            step(1);
        chk("taken", {7'h00, taken}, 8'h01);
        chk("ready at trig", {7'h00, ready}, 8'h00);
        step(1);
        chk("taken pulse", {7'h00, taken}, 8'h00);
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // free-running 100 MHz clock
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    // hang guard, far above the roughly sixty cycles needed
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            num_errors++;
            stop_test();
        end
    end

    initial
    begin
        step(1);
        chk("reset lines", lines, 8'hFF);
        chk("reset bit7", {7'h00, bit7_n}, 8'h01);
        chk("reset flags", {6'h00, done, ready}, 8'h00);
        step(1);
        rst_i = 1'b0;
        // plain port data, inverted on the lines
        port_b_i = 8'hA5;
        first_output_bit7_i = 1'b1;
        step(2);
        chk("port lines", lines, 8'h5A);
        chk("bit7 line", {7'h00, bit7_n}, 8'h00);
        $display("port test done");
        // shared pins take status and ignore the port bits
        port_b_i = 8'hC0;
        done_sel_i = 1'b1;
        ready_sel_i = 1'b1;
        step(2);
        chk("shared idle", lines, 8'hFF);
        $display("select test done");
        // sweep without point trigger
        ev(4'h8);
        step(2);
        chk("ready armed", {7'h00, ready}, 8'h01);
        chk("ready line", lines, 8'h7F);
        trig();
        step(1);
        chk("ready line off", lines, 8'hFF);
        // point ready means nothing while point trigger is off
        ev(4'h4);
        step(2);
        chk("no point rearm", {7'h00, ready}, 8'h00);
        ev(4'h2);
        step(2);
        chk("no rearm", {7'h00, ready}, 8'h00);
        // a trigger while idle must be dropped without a taken pulse
        fire = 1'b1;
        step(1);
        fire = 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            step(1);
            chk("idle trig", {7'h00, taken}, 8'h00);
        end
        ev(4'h1);
        step(2);
        chk("done flag", {7'h00, done}, 8'h01);
        chk("done line", lines, 8'hBF);
        ev(4'h8);
        step(2);
        chk("rearm", lines, 8'h3F);
        $display("sweep test done");
        // sweep with point trigger
        point_trig_en_i = 1'b1;
        trig();
        chk("done cleared", {7'h00, done}, 8'h00);
        chk("lines meas", lines, 8'hFF);
        ev(4'h4);
        step(2);
        chk("point ready", {7'h00, ready}, 8'h01);
        chk("point line", lines, 8'h7F);
        trig();
        ev(4'h2);
        ev(4'h1);
        step(2);
        chk("done end", lines, 8'hBF);
        $display("point test done");
        stop_test();
    end
endmodule
